// ### logic/cfg_readback_pkg.sv
// ----------------------------------------------------------------------------
// readback sequencer constants
// ----------------------------------------------------------------------------
package cfg_readback_pkg;

   // ----------------------------------------------------------------------------
   // packet words
   // ----------------------------------------------------------------------------
   localparam logic [15:0] DUMMY_WORD       = 16'hFFFF;
   localparam logic [15:0] SYNC_WORD_HI     = 16'hAA99;
   localparam logic [15:0] SYNC_WORD_LO     = 16'h5566;
   localparam logic [15:0] NO_OPERATION     = 16'h2000;
   localparam logic [15:0] HDR_WRITE_CMD    = 16'h30A1;
   localparam logic [15:0] HDR_WRITE_FLEN   = 16'h31A1;
   localparam logic [15:0] HDR_WRITE_FADDR  = 16'h3022;
   localparam logic [15:0] HDR_READ_FDATA   = 16'h4880;
   localparam logic [15:0] CMD_SHUTDOWN     = 16'h000B;
   localparam logic [15:0] CMD_CRC_RESET    = 16'h0007;
   localparam logic [15:0] CMD_ICON_DISABLE = 16'h0008;
   localparam logic [15:0] CMD_READ_CONFIG  = 16'h0004;
   localparam logic [15:0] CMD_LAST_FRAME   = 16'h0003;
   localparam logic [15:0] CMD_START        = 16'h0005;
   localparam logic [15:0] CMD_SYNC_DROP    = 16'h000D;

   // ----------------------------------------------------------------------------
   // repeat counts
   // ----------------------------------------------------------------------------
   localparam int DUMMY_COUNT     = 4;
   localparam int SHUTDOWN_NOOPS  = 16;
   localparam int FLUSH_NOOPS     = 66;   // one plus 65 more
   localparam int START_NOOPS     = 4;
   localparam int TAIL_NO_OPERATION_WORD_BITS  = 64;
   localparam int DIR_GAP_CYCLES  = 1;

   // ----------------------------------------------------------------------------
   // job request and result word carriers
   // ----------------------------------------------------------------------------
   typedef struct packed {
      logic [15:0] frame_len;    // words per frame
      logic [15:0] addr_major;
      logic [15:0] addr_minor;
      logic [15:0] frames;       // frames wanted
   } job_s;

   typedef struct packed {
      logic        last;
      logic [15:0] data;
   } rd_word_s;

endpackage

// ### logic/link_word_sync.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------------------
// toggle handshake: one word from source clock to destination clock
// ----------------------------------------------------------------------------
module link_word_sync #(
   parameter int W = 17
) (
   // source side
   input  wire logic         i_src_clk,
   input  wire logic         i_src_rst_n,
   input  wire logic         i_src_pulse,  // one-cycle load
   input  wire logic [W-1:0] i_src_data,
   // destination side
   input  wire logic         i_dst_clk,
   input  wire logic         i_dst_rst_n,
   output logic              o_dst_pulse,
   output logic [W-1:0]      o_dst_data
);
   logic [W-1:0] hold;     // stable while toggle crosses
   logic         tog;      // source toggle
   logic         s1;       // first stage, read only by s2
   logic         s2;
   logic         s3;       // edge reference

   // source: capture and flip
   always_ff @(posedge i_src_clk or negedge i_src_rst_n) begin
      if (!i_src_rst_n) begin
         hold <= '0;
         tog  <= 1'b0;
      end else if (i_src_pulse) begin
         hold <= i_src_data;
         tog  <= ~tog;
      end
   end

   // destination: sync and detect the flip
   always_ff @(posedge i_dst_clk or negedge i_dst_rst_n) begin
      if (!i_dst_rst_n) begin
         s1          <= 1'b0;
         s2          <= 1'b0;
         s3          <= 1'b0;
         o_dst_pulse <= 1'b0;
         o_dst_data  <= '0;
      end else begin
         s1          <= tog;
         s2          <= s1;
         s3          <= s2;
         o_dst_pulse <= s2 ^ s3;
         // hold is stable for two dst edges before s2 flips
         if (s2 ^ s3) begin
            o_dst_data <= hold;
         end
      end
   end
endmodule

// ### logic/cfg_readback_host.sv
`timescale 1ns/1ns
module cfg_readback_host
   import cfg_readback_pkg::*;
#(
   parameter int BYTE_WIDTH = 0    // 1: 8-bit port, 0: 16-bit port
) (
   // system
   input  wire logic                         I_SYS_CLK,
   input  wire logic                         I_RST_N,
   // job request (system clock)
   input  wire logic                         I_START,
   input  wire cfg_readback_pkg::job_s       I_JOB,
   output logic                              O_BUSY,
   output logic                              O_DONE_PULSE,
   // readback words out (system clock)
   output logic                              O_RD_VALID,
   output cfg_readback_pkg::rd_word_s        O_RD_WORD,
   // link (link clock, supplied by the bench)
   input  wire logic                         I_LINK_CLK,
   input  wire logic                         I_LINK_RST_N,
   output logic                              O_CS_N,
   output logic                              O_PORT_DIRECTION,
   output logic [15:0]                       O_DATA,
   output logic                              O_DATA_OE,
   input  wire logic [15:0]                  I_DATA,
   input  wire logic                         I_OUT_BUSY,
   input  wire logic                         I_DONE
);
   // ----------------------------------------------------------------------------
   // steps of the sequence, each step but S_IDLE, S_TO_RD, S_TO_WR and S_WAIT_DONE is a word group on the link
   // ----------------------------------------------------------------------------
   typedef enum {
      S_IDLE, S_DUMMY, S_SYNC1, S_SYNC2, S_NOOP1,
      S_SHUT_H, S_SHUT_C, S_SHUT_N,
      S_CRC1_H, S_CRC1_C, S_CRC1_N,
      S_DIS_H, S_DIS_C, S_DIS_N,
      S_FLEN_H, S_FLEN_D,
      S_FADR_H, S_FADR_MAJ, S_FADR_MIN,
      S_RDCFG_H, S_RDCFG_C,
      S_RDH, S_RDCNT, S_FLUSH,
      S_TO_RD, S_READ, S_TO_WR,
      S_LAST_H, S_LAST_C, S_LAST_N,
      S_STRT_H, S_STRT_C, S_STRT_N,
      S_CRC2_H, S_CRC2_C, S_CRC2_N,
      S_DSYN_H, S_DSYN_C, S_DSYN_N,
      S_WAIT_DONE
   } step_e;

   localparam int TAIL_NOOPS   = (TAIL_NO_OPERATION_WORD_BITS + 15) / 16;
   localparam int EXTRA_WORDS  = (BYTE_WIDTH != 0) ? 1 : 0;

   // ----------------------------------------------------------------------------
   // crossings: start request into the link domain, finish pulse and read words back to the system domain
   // ----------------------------------------------------------------------------
   logic       lk_start;        // one-cycle pulse on link clock
   logic       lk_start_unused;
   logic       lk_fin;          // link finished, pulse
   logic       sy_fin;
   logic       sy_fin_unused;
   job_s       job;             // captured in system domain, stable while busy
   rd_word_s   lk_word;         // word handed to system domain
   logic       lk_word_pulse;

   link_word_sync #(.W(1)) u_start_sync (
      .i_src_clk   (I_SYS_CLK),
      .i_src_rst_n (I_RST_N),
      .i_src_pulse (I_START && !O_BUSY),
      .i_src_data  (1'b1),
      .i_dst_clk   (I_LINK_CLK),
      .i_dst_rst_n (I_LINK_RST_N),
      .o_dst_pulse (lk_start),
      .o_dst_data  (lk_start_unused)
   );

   link_word_sync #(.W(1)) u_fin_sync (
      .i_src_clk   (I_LINK_CLK),
      .i_src_rst_n (I_LINK_RST_N),
      .i_src_pulse (lk_fin),
      .i_src_data  (1'b1),
      .i_dst_clk   (I_SYS_CLK),
      .i_dst_rst_n (I_RST_N),
      .o_dst_pulse (sy_fin),
      .o_dst_data  (sy_fin_unused)
   );

   // words cross by toggle; link word rate must leave three sys edges per word
   link_word_sync #(.W($bits(rd_word_s))) u_word_sync (
      .i_src_clk   (I_LINK_CLK),
      .i_src_rst_n (I_LINK_RST_N),
      .i_src_pulse (lk_word_pulse),
      .i_src_data  (lk_word),
      .i_dst_clk   (I_SYS_CLK),
      .i_dst_rst_n (I_RST_N),
      .o_dst_pulse (O_RD_VALID),
      .o_dst_data  (O_RD_WORD)
   );

   // ----------------------------------------------------------------------------
   // system domain: busy flag and job capture
   // ----------------------------------------------------------------------------
   // job is held during the whole run, so the link may read it directly
   always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         O_BUSY       <= 1'b0;
         O_DONE_PULSE <= 1'b0;
         job          <= '0;
      end else begin
         O_DONE_PULSE <= sy_fin;
         if (I_START && !O_BUSY) begin
            O_BUSY <= 1'b1;
            job    <= I_JOB;
         end else if (sy_fin) begin
            O_BUSY <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------------------
   // link domain: pin synchronisers
   // ----------------------------------------------------------------------------
   logic        busy_s1, busy_s2;   // output-busy flag
   logic        done_s1, done_s2;
   logic [15:0] data_s1, data_s2;

   // first stages feed only the second stages
   always_ff @(posedge I_LINK_CLK or negedge I_LINK_RST_N) begin
      if (!I_LINK_RST_N) begin
         busy_s1 <= 1'b1;
         busy_s2 <= 1'b1;
         done_s1 <= 1'b0;
         done_s2 <= 1'b0;
         data_s1 <= '0;
         data_s2 <= '0;
      end else begin
         busy_s1 <= I_OUT_BUSY;
         busy_s2 <= busy_s1;
         done_s1 <= I_DONE;
         done_s2 <= done_s1;
         data_s1 <= I_DATA;
         data_s2 <= data_s1;
      end
   end

   // ----------------------------------------------------------------------------
   // link domain: sequencer
   // ----------------------------------------------------------------------------
   step_e       step;
   logic [15:0] rep;        // repeat counter inside a step
   logic [31:0] rd_total;   // words still to collect
   logic [31:0] frame_words;// words left in dropped frame
   logic [31:0] read_len;

   // read count includes the buffer's dummy frame and trailing word
   assign read_len = 32'(job.frame_len) * (32'(job.frames) + 32'd1) + 32'd1;

   // word put on the bus for each write step
   function automatic logic [15:0] word_of(input step_e s, input job_s j,
                                           input logic [31:0] len);
      case (s)
         S_DUMMY:                                  word_of = DUMMY_WORD;
         S_SYNC1:                                  word_of = SYNC_WORD_HI;
         S_SYNC2:                                  word_of = SYNC_WORD_LO;
         S_SHUT_H, S_CRC1_H, S_DIS_H, S_RDCFG_H,
         S_LAST_H, S_STRT_H, S_CRC2_H, S_DSYN_H:   word_of = HDR_WRITE_CMD;
         S_SHUT_C:                                 word_of = CMD_SHUTDOWN;
         S_CRC1_C, S_CRC2_C:                       word_of = CMD_CRC_RESET;
         S_DIS_C:                                  word_of = CMD_ICON_DISABLE;
         S_FLEN_H:                                 word_of = HDR_WRITE_FLEN;
         S_FLEN_D:                                 word_of = j.frame_len;
         S_FADR_H:                                 word_of = HDR_WRITE_FADDR;
         S_FADR_MAJ:                               word_of = j.addr_major;
         S_FADR_MIN:                               word_of = j.addr_minor;
         S_RDCFG_C:                                word_of = CMD_READ_CONFIG;
         S_RDH:                                    word_of = HDR_READ_FDATA;
         S_RDCNT:                                  word_of = len[15:0];
         S_LAST_C:                                 word_of = CMD_LAST_FRAME;
         S_STRT_C:                                 word_of = CMD_START;
         S_DSYN_C:                                 word_of = CMD_SYNC_DROP;
         default:                                  word_of = NO_OPERATION;
      endcase
   endfunction

   // step order and repeat counts
   always_ff @(posedge I_LINK_CLK or negedge I_LINK_RST_N) begin
      if (!I_LINK_RST_N) begin
         step <= S_IDLE;
         rep  <= '0;
      end else begin
         case (step)
            S_IDLE:     if (lk_start) begin
                           step <= S_DUMMY;
                           rep  <= '0;
                        end
            S_DUMMY:    if (rep == 16'(DUMMY_COUNT - 1)) begin
                           step <= S_SYNC1;
                           rep  <= '0;
                        end else begin
                           rep <= rep + 16'd1;
                        end
            S_SHUT_N:   if (rep == 16'(SHUTDOWN_NOOPS - 1)) begin
                           step <= S_CRC1_H;
                           rep  <= '0;
                        end else begin
                           rep <= rep + 16'd1;
                        end
            S_FLUSH:    if (rep == 16'(FLUSH_NOOPS - 1)) begin
                           step <= S_TO_RD;
                           rep  <= '0;
                        end else begin
                           rep <= rep + 16'd1;
                        end
            // deselected for exactly one cycle while direction flips
            S_TO_RD:    step <= S_READ;
            S_READ:     if (busy_s2 == 1'b0 && rd_total == 32'd1) begin
                           step <= S_TO_WR;
                        end
            S_TO_WR:    step <= S_LAST_H;
            S_STRT_N:   if (rep == 16'(START_NOOPS - 1)) begin
                           step <= S_CRC2_H;
                           rep  <= '0;
                        end else begin
                           rep <= rep + 16'd1;
                        end
            S_DSYN_N:   if (rep == 16'(TAIL_NOOPS - 1)) begin
                           step <= S_WAIT_DONE;
                           rep  <= '0;
                        end else begin
                           rep <= rep + 16'd1;
                        end
            S_WAIT_DONE: if (done_s2) begin
                           step <= S_IDLE;
                        end
            S_DSYN_C:   begin
                           step <= S_DSYN_N;
                           rep  <= '0;
                        end
            default:    step <= step_e'(int'(step) + 1);
         endcase
      end
   end

   // ----------------------------------------------------------------------------
   // link domain: pins; word shown from the edge after a step begins
   // ----------------------------------------------------------------------------
   always_ff @(posedge I_LINK_CLK or negedge I_LINK_RST_N) begin
      if (!I_LINK_RST_N) begin
         O_CS_N           <= 1'b1;
         O_PORT_DIRECTION <= 1'b0;
         O_DATA           <= '0;
         O_DATA_OE        <= 1'b0;
      end else begin
         O_DATA <= word_of(step, job, read_len);
         case (step)
            S_IDLE: begin
               O_CS_N    <= 1'b1;
               O_DATA_OE <= 1'b0;
            end
            S_TO_RD, S_TO_WR: begin
               O_CS_N    <= 1'b1;
               O_DATA_OE <= 1'b0;
            end
            S_READ: begin
               O_CS_N    <= 1'b0;
               O_DATA_OE <= 1'b0;
            end
            // clock keeps running for done; bus idles deselected
            S_WAIT_DONE: begin
               O_CS_N    <= 1'b1;
               O_DATA_OE <= 1'b0;
            end
            default: begin
               O_CS_N    <= 1'b0;
               O_DATA_OE <= 1'b1;
            end
         endcase
         // direction changes only while deselected
         if (step == S_TO_RD) begin
            O_PORT_DIRECTION <= 1'b1;
         end else if (step == S_TO_WR) begin
            O_PORT_DIRECTION <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------------------
   // link domain: collect words while output-busy is low
   // ----------------------------------------------------------------------------
   // latency dummies show as busy high, so only busy gates sampling
   always_ff @(posedge I_LINK_CLK or negedge I_LINK_RST_N) begin
      if (!I_LINK_RST_N) begin
         rd_total      <= '0;
         frame_words   <= '0;
         lk_word       <= '0;
         lk_word_pulse <= 1'b0;
         lk_fin        <= 1'b0;
      end else begin
         lk_word_pulse <= 1'b0;
         lk_fin        <= (step == S_WAIT_DONE) && done_s2;
         if (step == S_FLUSH) begin
            rd_total    <= read_len + 32'(EXTRA_WORDS);
            frame_words <= 32'(job.frame_len);
         end else if (step == S_READ && busy_s2 == 1'b0 && rd_total != 32'd0) begin
            rd_total <= rd_total - 32'd1;
            if (frame_words != 32'd0) begin
               frame_words <= frame_words - 32'd1;
            end else begin
               lk_word.data  <= data_s2;
               lk_word.last  <= (rd_total == 32'd1);
               lk_word_pulse <= 1'b1;
            end
         end
      end
   end
endmodule

// ### test/cfg_readback_checker.sv
`timescale 1ns/1ns
// ----------------------------------------
// protocol checker on the host's ports
// ----------------------------------------
module cfg_readback_checker #(
   parameter int BYTE_WIDTH = 0  // 1: byte port; extra word is read, not requested
) (
   // system side
   input  wire logic                   I_SYS_CLK,
   input  wire logic                   I_RST_N,
   input  wire cfg_readback_pkg::job_s I_JOB,
   input  wire logic                   O_BUSY,
   input  wire logic                   O_RD_VALID,
   // link side
   input  wire logic                   I_LINK_CLK,
   input  wire logic                   I_LINK_RST_N,
   input  wire logic                   O_CS_N,
   input  wire logic                   O_PORT_DIRECTION,
   input  wire logic [15:0]            O_DATA,
   input  wire logic                   O_DATA_OE
);
   import cfg_readback_pkg::*;

   logic [15:0] exp_cnt;   // read count the I_JOB input asks for
   logic [6:0]  no_operation_word_run;  // consecutive no-ops written

   // requested count excludes the byte-width extra word, which is only collected
   assign exp_cnt = 16'(I_JOB.frame_len * (I_JOB.frames + 16'd1) + 16'd1);

   // run length of no-ops; idle cycles keep it, any other word clears it
   always_ff @(posedge I_LINK_CLK or negedge I_LINK_RST_N) begin
      if (!I_LINK_RST_N) begin
         no_operation_word_run <= 7'd0;
      end else if (!O_CS_N && O_DATA_OE) begin
         no_operation_word_run <= (O_DATA == NO_OPERATION) ? no_operation_word_run + 7'd1 : 7'd0;
      end
   end

   // one written word on the link
   sequence wr(logic [15:0] w);
      !O_CS_N && O_DATA_OE && O_DATA == w;
   endsequence
   sequence no_operation_word;
      wr(NO_OPERATION);
   endsequence

   chk_sync_preamble: assert property (
      @(posedge I_LINK_CLK) disable iff (!I_LINK_RST_N)
      wr(SYNC_WORD_HI) |-> $past(O_DATA, 4) == DUMMY_WORD ##1 wr(SYNC_WORD_LO) ##1 no_operation_word
         ##1 wr(HDR_WRITE_CMD) ##1 wr(CMD_SHUTDOWN))
      else $error("sync preamble out of order");
   chk_shutdown_noops: assert property (
      @(posedge I_LINK_CLK) disable iff (!I_LINK_RST_N)
      wr(CMD_SHUTDOWN) |=> no_operation_word[*8] ##1 no_operation_word[*8] ##1 wr(HDR_WRITE_CMD) ##1 wr(CMD_CRC_RESET))
      else $error("shutdown not followed by sixteen no-ops");
   chk_icon_flen: assert property (
      @(posedge I_LINK_CLK) disable iff (!I_LINK_RST_N)
      wr(CMD_ICON_DISABLE) |=> no_operation_word ##1 wr(HDR_WRITE_FLEN) ##1 wr(I_JOB.frame_len))
      else $error("frame length write wrong");
   chk_addr_read_count: assert property (
      @(posedge I_LINK_CLK) disable iff (!I_LINK_RST_N)
      wr(HDR_WRITE_FADDR) |=> wr(I_JOB.addr_major) ##1 wr(I_JOB.addr_minor) ##1 wr(HDR_WRITE_CMD)
         ##1 wr(CMD_READ_CONFIG) ##1 wr(HDR_READ_FDATA) ##1 wr(exp_cnt))
      else $error("address or read request wrong");
   chk_flush_count: assert property (
      @(posedge I_LINK_CLK) disable iff (!I_LINK_RST_N)
      $rose(O_PORT_DIRECTION) |-> no_operation_word_run == 7'(FLUSH_NOOPS))
      else $error("flush no-op count wrong");
   chk_restart_tail: assert property (
      @(posedge I_LINK_CLK) disable iff (!I_LINK_RST_N)
      wr(CMD_LAST_FRAME) |=> no_operation_word ##1 wr(HDR_WRITE_CMD) ##1 wr(CMD_START) ##1 no_operation_word[*4]
         ##1 wr(HDR_WRITE_CMD) ##1 wr(CMD_CRC_RESET) ##1 no_operation_word ##1 wr(HDR_WRITE_CMD)
         ##1 wr(CMD_SYNC_DROP) ##1 no_operation_word[*4])
      else $error("closing sequence wrong");
   chk_dir_deselect: assert property (
      @(posedge I_LINK_CLK) disable iff (!I_LINK_RST_N)
      $changed(O_PORT_DIRECTION) |-> O_CS_N ##1 !O_CS_N)
      else $error("direction changed while selected");
   chk_read_no_drive: assert property (
      @(posedge I_LINK_CLK) disable iff (!I_LINK_RST_N)
      O_PORT_DIRECTION |-> !O_DATA_OE)
      else $error("host drives bus in read direction");
   chk_valid_in_run: assert property (
      @(posedge I_SYS_CLK) disable iff (!I_RST_N)
      O_RD_VALID |-> O_BUSY)
      else $error("read word outside a run");
endmodule

// ### test/cfg_dev_model.sv
`timescale 1ns/1ns
// ----------------------------------------
// far-end device: watches writes, streams frame words on read
// ----------------------------------------
module cfg_dev_model #(
   parameter int LAT = 2  // dummy clocks after select
) (
   // link
   input  wire logic        i_clk,
   input  wire logic        i_cs_n,
   input  wire logic        i_dir,
   input  wire logic        i_oe,
   input  wire logic [15:0] i_data,
   input  wire logic [3:0]  i_gap,   // link cycles per word, slow or prompt
   // answers
   output logic             o_busy,
   output logic [15:0]      o_data,
   output logic             o_done
);
   import cfg_readback_pkg::*;

   int   sel_cyc;  // cycles selected for read
   int   idx;      // words returned in this read
   int   pace;     // cycles to next word
   int   noops;    // no-ops since sync drop
   logic armed;    // sync drop seen, counting no-ops

   initial begin
      o_busy = 1'b1;
      o_data = 16'h0000;
      o_done = 1'b1;
      armed  = 1'b0;
   end

   // all sampling on the link clock edge, as the port does
   always @(posedge i_clk) begin
      // write side: sync lowers done, sync drop plus 64 bits of no-ops raises it
      if (!i_cs_n && !i_dir && i_oe) begin
         if (i_data == SYNC_WORD_HI) o_done <= 1'b0;
         if (i_data == CMD_SYNC_DROP) begin
            armed <= 1'b1;
            noops <= 0;
         end else if (armed && i_data == NO_OPERATION) begin
            noops <= noops + 1;
            if (noops + 1 == TAIL_NO_OPERATION_WORD_BITS / 16) begin
               o_done <= 1'b1;
               armed  <= 1'b0;
            end
         end
      end
      // bus not valid: flag high, data changes every cycle so stale words never match
      o_busy <= 1'b1;
      o_data <= ~o_data;
      if (!i_cs_n && i_dir) begin
         sel_cyc <= sel_cyc + 1;
         if (sel_cyc >= LAT && pace == 0) begin
            o_busy <= 1'b0;
            o_data <= 16'(idx) * 16'h0101 ^ 16'hC35A;
            idx    <= idx + 1;
            pace   <= int'(i_gap) - 1;
         end else if (pace > 0) begin
            pace <= pace - 1;
         end
      end else begin
         sel_cyc <= 0;
         idx     <= 0;
         pace    <= 0;
      end
   end
endmodule

// ### test/cfg_readback_host_tb.sv
`timescale 1ns/1ns
// ----------------------------------------
// testbench: random jobs, words checked against the device pattern
// ----------------------------------------
module cfg_readback_host_tb;
   import cfg_readback_pkg::*;
   localparam int BW    = 0;      // 16-bit port
   localparam int LIMIT = 30000;  // sys cycles; five runs need far fewer

   logic        sys_clk  = 1'b0;
   logic        link_clk = 1'b0;
   logic        rst_n    = 1'b0;
   logic        start    = 1'b0;
   job_s        job      = '0;
   logic [15:0] seed     = 16'h0043;
   logic [3:0]  gap      = 4'hC;    // twelve link cycles per word at most pace
   logic        busy, done_p, rd_valid, cs_n, dir, oe, dev_busy, dev_done;
   rd_word_s    rd_word;
   logic [15:0] wdata, ddata;
   int          n_mismatch = 0;
   int          num_checks = 0;
   int          cyc        = 0;

   // clocks unrelated in phase
   always #10 sys_clk = ~sys_clk;
   always #3 link_clk = ~link_clk;

   cfg_readback_host #(.BYTE_WIDTH(BW)) DUT (
      .I_SYS_CLK(sys_clk), .I_RST_N(rst_n), .I_START(start), .I_JOB(job),
      .O_BUSY(busy), .O_DONE_PULSE(done_p), .O_RD_VALID(rd_valid), .O_RD_WORD(rd_word),
      .I_LINK_CLK(link_clk), .I_LINK_RST_N(rst_n), .O_CS_N(cs_n),
      .O_PORT_DIRECTION(dir), .O_DATA(wdata), .O_DATA_OE(oe), .I_DATA(ddata),
      .I_OUT_BUSY(dev_busy), .I_DONE(dev_done));

   cfg_dev_model #(.LAT(BW ? 3 : 2)) u_dev (
      .i_clk(link_clk), .i_cs_n(cs_n), .i_dir(dir), .i_oe(oe), .i_data(wdata),
      .i_gap(gap), .o_busy(dev_busy), .o_data(ddata), .o_done(dev_done));

   // hang guard
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         n_mismatch++;
         tally_and_finish();
      end
   end

   function automatic logic [15:0] nxt(logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   // word the device returns at position i of a read
   function automatic logic [15:0] dev_word(int i);
      return 16'(i) * 16'h0101 ^ 16'hC35A;
   endfunction

   task automatic chk16(string what, logic [15:0] exp, logic [15:0] got);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic chk1(string what, logic exp, logic got);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %b seen %b", what, exp, got);
      end
   endtask

   // one run; a second start mid-run must be ignored
   task automatic run_job(logic [15:0] flen, logic [15:0] nfr, logic [15:0] maj,
                          logic [15:0] mnr);
      int k;
      k = 0;
      @(negedge sys_clk);
      job   = {flen, maj, mnr, nfr};
      start = 1'b1;
      @(negedge sys_clk);
      start = 1'b0;
      chk1("busy after start", 1'b1, busy);
      while (done_p !== 1'b1) begin
         @(negedge sys_clk);
         start = (rd_valid === 1'b1 && k == 1);
         if (rd_valid === 1'b1) begin
            chk16("read word", dev_word(int'(flen) + k), rd_word.data);
            chk1("last flag", 1'(k == int'(flen * nfr) + BW), rd_word.last);
            k++;
         end
      end
      chk16("word count", 16'(flen * nfr + 16'd1 + 16'(BW)), 16'(k));
      repeat (2) @(negedge sys_clk);
      chk1("busy after done", 1'b0, busy);
      $display("run done len %0d frames %0d words %0d", flen, nfr, k);
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      repeat (5) @(negedge sys_clk);
      rst_n = 1'b1;
      repeat (4) @(negedge sys_clk);
      run_job(16'h0010, 16'h0000, 16'h0000, 16'h0000);
      for (int r = 0; r < 4; r++) begin
         seed = nxt(seed);
         gap  = r[0] ? 4'hF : 4'hC;
         // values kept clear of every header and command code
         run_job(16'h0010 + {14'h0, seed[1:0]}, {14'h0, seed[3:2]}, {4'h1, seed[11:0]},
                 {4'h1, seed[15:4]});
      end
      tally_and_finish();
   end
endmodule

bind cfg_readback_host cfg_readback_checker #(.BYTE_WIDTH(BYTE_WIDTH)) u_chk (
   .I_SYS_CLK(I_SYS_CLK), .I_RST_N(I_RST_N), .I_JOB(I_JOB), .O_BUSY(O_BUSY),
   .O_RD_VALID(O_RD_VALID), .I_LINK_CLK(I_LINK_CLK), .I_LINK_RST_N(I_LINK_RST_N),
   .O_CS_N(O_CS_N), .O_PORT_DIRECTION(O_PORT_DIRECTION), .O_DATA(O_DATA),
   .O_DATA_OE(O_DATA_OE));
